/* File: src/fault_diag_pkg.sv */
// Package: offsets, field positions, reset values and states of the cell fault block.
// Assumes a 32-bit APB slave port and a single pclk domain.
package fault_diag_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_FAULT_SETUP  = 8'h00;
    localparam logic [7:0] ADDR_CELL_SETUP   = 8'h04;
    localparam logic [7:0] ADDR_DEVICE_SETUP = 8'h08;
    localparam logic [7:0] ADDR_UV_LIMIT     = 8'h0C;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h10;
    localparam logic [7:0] ADDR_UV_FAULT     = 8'h14;
    localparam logic [7:0] ADDR_WIRE_FAULT   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h1C;
    localparam logic [7:0] ADDR_COMMAND      = 8'h20;

    // ==========================================================
    // Reset values
    localparam logic [2:0]  FILTER_CODE_RST = 3'h3;     // Eight samples
    localparam logic [11:0] CELL_SETUP_RST  = 12'h000;
    localparam logic        SCAN_CUR_RST    = 1'b1;      // 1 mA
    localparam logic [13:0] UV_LIMIT_RST    = 14'h0000;
    localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;

    // Full-scale limit code stands for 5 V
    localparam logic [13:0] UV_FULL_SCALE   = 14'h1FFF;

    // ==========================================================
    // Fault status bit positions
    localparam int unsigned ST_UV     = 0;
    localparam int unsigned ST_SUPPLY = 1;
    localparam int unsigned ST_GND    = 2;
    localparam int unsigned ST_WIRE   = 3;

    // Command register bit positions
    localparam int unsigned CMD_SCAN_VOLT = 0;
    localparam int unsigned CMD_SCAN_WIRE = 1;

    // ==========================================================
    // Scan sequencer states
    typedef enum logic [2:0] {
        SCAN_IDLE = 3'b001,
        SCAN_VOLT = 3'b010,
        SCAN_WIRE = 3'b100
    } scan_state_e;

endpackage : fault_diag_pkg

/* File: src/consec_filter.sv */
// Consecutive-sample filter for one monitored condition.
// Assumes sample strobes and conditions come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module consec_filter #(
    parameter int unsigned CW = 8
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       sample,
    input  wire logic       cond,
    input  wire logic [2:0] len_code,
    output logic            trip
);

    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [CW-1:0] limit;
    logic [CW-1:0] count_inc;

    // Length is two to the power of the code
    assign limit     = CW'(1) << len_code;
    assign count_inc = count_q + CW'(1);

    // Trips on the sample that completes the run
    assign trip = sample & cond & (count_inc >= limit);

    // Count saturates at the limit so it never wraps
    always_comb begin
        count_d = count_q;
        if (clear) begin
            count_d = '0;
        end else if (sample) begin
            count_d = cond ? ((count_q >= limit) ? count_q : count_inc) : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    clear_zeroes_a: assert property (@(posedge pclk) disable iff (!presetn)
        clear |=> count_q == '0) else $error("filter count not cleared");
    false_zeroes_a: assert property (@(posedge pclk) disable iff (!presetn)
        sample && !cond |=> count_q == '0) else $error("false sample kept count");

endmodule : consec_filter
`default_nettype wire

/* File: src/cell_fault_diagnostics.sv */
// Cell fault diagnostics: undervoltage, supply/ground open and open-wire checks.
// Assumes an APB master on pclk and a measurement path on the same clock.
//
// How it works
// - Unused cell inputs skip undervoltage check
// - Undervoltage fault after programmed consecutive samples
// - Sample-count field resets to eight samples
// - First fault sends status word unprompted
// - Changing sample-count field clears filter counters
// - Good sample zeroes that cell's count
// - Pin open fault after consecutive readings
// - Closed-pin sample zeroes the open count
// - Current select: 1 gives 1mA, 0 150uA
// - Unused inputs two to twelve skip open-wire
// - Inputs zero and one always tested
// - Limit code 14'h1FFF is five volts
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module cell_fault_diagnostics #(
    parameter int unsigned NUM_CELLS = 12
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 sample_valid,
    input  wire logic [3:0]           sample_cell,
    input  wire logic [13:0]          sample_code,
    input  wire logic                 sample_supply_open,
    input  wire logic                 sample_gnd_open,
    input  wire logic                 volt_scan_done,
    input  wire logic                 wire_scan_done,
    input  wire logic [NUM_CELLS:0]   wire_open,
    output logic                      volt_scan_start,
    output logic                      wire_scan_start,
    output logic                      scan_current_select,
    output logic [NUM_CELLS:0]        wire_enable,
    output logic                      status_send,
    output logic [3:0]                status_word,
    output logic                      irq
);

    // ==========================================================
    // Register state
    logic [2:0]             code_q, code_d;
    logic [NUM_CELLS-1:0]   cell_setup_q, cell_setup_d;
    logic                   iscan_q, iscan_d;
    logic [13:0]            uv_limit_q, uv_limit_d;
    logic [3:0]             status_q, status_d;
    logic [NUM_CELLS-1:0]   uv_fault_q, uv_fault_d;
    logic [NUM_CELLS:0]     wire_fault_q, wire_fault_d;
    logic [3:0]             mask_q, mask_d;
    logic [31:0]            prdata_q, prdata_d;
    logic                   pready_q, pready_d;
    logic                   pslverr_q, pslverr_d;
    logic                   send_q, send_d;
    logic [3:0]             word_q, word_d;
    logic                   irq_q, irq_d;
    logic [NUM_CELLS:0]     wen_q, wen_d;
    fault_diag_pkg::scan_state_e state_q, state_d;
    logic                   vstart_q, vstart_d;
    logic                   wstart_q, wstart_d;

    logic                   wr_en;
    logic                   filt_clear;
    logic                   in_volt;
    logic [NUM_CELLS-1:0]   uv_trip;
    logic                   sup_trip, gnd_trip;
    logic [3:0]             st_set;
    logic [3:0]             st_clr;
    logic [NUM_CELLS-1:0]   uv_set;
    logic [NUM_CELLS:0]     wire_set;

    // Write lands only on the completing access edge
    assign wr_en   = psel & penable & pwrite & pready_q;
    assign in_volt = (state_q == fault_diag_pkg::SCAN_VOLT);

    assign filt_clear = wr_en && (paddr == fault_diag_pkg::ADDR_FAULT_SETUP) && (pwdata[2:0] != code_q);

    // ==========================================================
    // Filters, one per cell plus supply and ground pins
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CELLS; gi++) begin : g_uv
            logic hit_cell;
            assign hit_cell = (sample_cell == 4'(gi));
            consec_filter u_uv (
                .pclk     (pclk),
                .presetn  (presetn),
                .clear    (filt_clear),
                .sample   (sample_valid & in_volt & hit_cell & ~cell_setup_q[gi]),
                .cond     (sample_code < uv_limit_q),
                .len_code (code_q),
                .trip     (uv_trip[gi])
            );
        end
    endgenerate

    consec_filter u_sup (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (filt_clear),
        .sample   (sample_valid & in_volt),
        .cond     (sample_supply_open),
        .len_code (code_q),
        .trip     (sup_trip)
    );

    consec_filter u_gnd (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (filt_clear),
        .sample   (sample_valid & in_volt),
        .cond     (sample_gnd_open),
        .len_code (code_q),
        .trip     (gnd_trip)
    );

    // ==========================================================
    // Fault event collection
    always_comb begin
        uv_set   = uv_trip;
        // Wire results only count at the end of a wire scan
        wire_set = (wire_scan_done && state_q == fault_diag_pkg::SCAN_WIRE) ? (wire_open & wen_q) : '0;
        st_set   = '0;
        st_set[fault_diag_pkg::ST_UV]     = |uv_set;
        st_set[fault_diag_pkg::ST_SUPPLY] = sup_trip;
        st_set[fault_diag_pkg::ST_GND]    = gnd_trip;
        st_set[fault_diag_pkg::ST_WIRE]   = |wire_set;
        st_clr = (wr_en && paddr == fault_diag_pkg::ADDR_FAULT_STATUS) ? pwdata[3:0] : 4'h0;
    end

    // ==========================================================
    // Setup and fault registers, next values
    always_comb begin
        code_d       = code_q;
        cell_setup_d = cell_setup_q;
        iscan_d      = iscan_q;
        uv_limit_d   = uv_limit_q;
        mask_d       = mask_q;
        status_d     = (status_q & ~st_clr) | st_set;
        uv_fault_d   = uv_fault_q | uv_set;
        wire_fault_d = wire_fault_q | wire_set;
        if (wr_en) begin
            case (paddr)
                fault_diag_pkg::ADDR_FAULT_SETUP:  code_d       = pwdata[2:0];
                fault_diag_pkg::ADDR_CELL_SETUP:   cell_setup_d = pwdata[NUM_CELLS-1:0];
                fault_diag_pkg::ADDR_DEVICE_SETUP: iscan_d      = pwdata[0];
                fault_diag_pkg::ADDR_UV_LIMIT:     uv_limit_d   = pwdata[13:0];
                fault_diag_pkg::ADDR_IRQ_MASK:     mask_d       = pwdata[3:0];
                fault_diag_pkg::ADDR_UV_FAULT:     uv_fault_d   = (uv_fault_q & ~pwdata[NUM_CELLS-1:0]) | uv_set;
                fault_diag_pkg::ADDR_WIRE_FAULT:   wire_fault_d = (wire_fault_q & ~pwdata[NUM_CELLS:0]) | wire_set;
                default: ;
            endcase
        end
        for (int i = 2; i <= NUM_CELLS; i++) begin
            wen_d[i] = ~cell_setup_q[i-1];
        end
        wen_d[1:0] = 2'b11;
        send_d = (status_q == 4'h0) && (st_set != 4'h0);
        word_d = send_d ? status_d : word_q;
        irq_d  = |(status_d & mask_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_q       <= fault_diag_pkg::FILTER_CODE_RST;
            cell_setup_q <= fault_diag_pkg::CELL_SETUP_RST;
            iscan_q      <= fault_diag_pkg::SCAN_CUR_RST;
            uv_limit_q   <= fault_diag_pkg::UV_LIMIT_RST;
            mask_q       <= fault_diag_pkg::IRQ_MASK_RST;
            status_q     <= '0;
            uv_fault_q   <= '0;
            wire_fault_q <= '0;
            wen_q        <= '1;
            send_q       <= 1'b0;
            word_q       <= '0;
            irq_q        <= 1'b0;
        end else begin
            code_q       <= code_d;
            cell_setup_q <= cell_setup_d;
            iscan_q      <= iscan_d;
            uv_limit_q   <= uv_limit_d;
            mask_q       <= mask_d;
            status_q     <= status_d;
            uv_fault_q   <= uv_fault_d;
            wire_fault_q <= wire_fault_d;
            wen_q        <= wen_d;
            send_q       <= send_d;
            word_q       <= word_d;
            irq_q        <= irq_d;
        end
    end

    // ==========================================================
    // Scan sequencer; a new command while busy is ignored
    always_comb begin
        state_d  = state_q;
        vstart_d = 1'b0;
        wstart_d = 1'b0;
        case (state_q)
            fault_diag_pkg::SCAN_IDLE: begin
                if (wr_en && paddr == fault_diag_pkg::ADDR_COMMAND) begin
                    if (pwdata[fault_diag_pkg::CMD_SCAN_VOLT]) begin
                        state_d  = fault_diag_pkg::SCAN_VOLT;
                        vstart_d = 1'b1;
                    end else if (pwdata[fault_diag_pkg::CMD_SCAN_WIRE]) begin
                        state_d  = fault_diag_pkg::SCAN_WIRE;
                        wstart_d = 1'b1;
                    end
                end
            end
            fault_diag_pkg::SCAN_VOLT: if (volt_scan_done) state_d = fault_diag_pkg::SCAN_IDLE;
            // Busy shown until wire scan ends
            fault_diag_pkg::SCAN_WIRE: if (wire_scan_done) state_d = fault_diag_pkg::SCAN_IDLE;
            default: state_d = fault_diag_pkg::SCAN_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= fault_diag_pkg::SCAN_IDLE;
            vstart_q <= 1'b0;
            wstart_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            vstart_q <= vstart_d;
            wstart_q <= wstart_d;
        end
    end

    // ==========================================================
    // APB read path; data captured in setup, answered next cycle
    always_comb begin
        pready_d  = psel & ~penable;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            prdata_d = 32'h0000_0000;
            case (paddr)
                fault_diag_pkg::ADDR_FAULT_SETUP:  prdata_d[2:0]           = code_q;
                fault_diag_pkg::ADDR_CELL_SETUP:   prdata_d[NUM_CELLS-1:0] = cell_setup_q;
                fault_diag_pkg::ADDR_DEVICE_SETUP: prdata_d[0]             = iscan_q;
                fault_diag_pkg::ADDR_UV_LIMIT:     prdata_d[13:0]          = uv_limit_q;
                fault_diag_pkg::ADDR_FAULT_STATUS: prdata_d[3:0]           = status_q;
                fault_diag_pkg::ADDR_UV_FAULT:     prdata_d[NUM_CELLS-1:0] = uv_fault_q;
                fault_diag_pkg::ADDR_WIRE_FAULT:   prdata_d[NUM_CELLS:0]   = wire_fault_q;
                fault_diag_pkg::ADDR_IRQ_MASK:     prdata_d[3:0]           = mask_q;
                fault_diag_pkg::ADDR_COMMAND:      prdata_d[0]             = (state_q != fault_diag_pkg::SCAN_IDLE);
                default:                           pslverr_d               = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign scan_current_select = iscan_q;
    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign volt_scan_start     = vstart_q;
    assign wire_scan_start     = wstart_q;
    assign wire_enable         = wen_q;
    assign status_send         = send_q;
    assign status_word         = word_q;
    assign irq                 = irq_q;

    // ==========================================================
    // Checks
    sequence first_fault_s;
        status_q == 4'h0 && st_set != 4'h0;
    endsequence

    unused_no_uv_a: assert property (@(posedge pclk) disable iff (!presetn)
        sample_valid && cell_setup_q[sample_cell] |-> !uv_trip[sample_cell]) else $error("unused cell tripped");
    uv_needs_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(status_q[0]) |-> $past(|uv_trip)) else $error("uv fault without filter trip");
    code_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> code_q == 3'h3) else $error("filter code reset wrong");
    auto_send_a: assert property (@(posedge pclk) disable iff (!presetn)
        first_fault_s |=> status_send && status_word == $past(status_d)) else $error("first fault not sent");
    pin_needs_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(status_q[1]) |-> $past(sup_trip)) else $error("supply open without trip");
    current_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 8'h08 |=> ##1 scan_current_select == $past(pwdata[0], 2)) else $error("current select");
    low_inputs_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        wire_enable[1:0] == 2'b11) else $error("inputs zero or one disabled");
    fault_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(status_q[0]) |-> $past(st_clr[0])) else $error("status bit dropped unasked");

endmodule : cell_fault_diagnostics
`default_nettype wire

/* File: test/meas_path_model.sv */
// Measurement path model: answers scan start pulses with cell samples and wire results.
// Assumes the bench sets codes, open patterns and pacing before each scan starts.
`timescale 1ns/1ps
`default_nettype none

module meas_path_model (
    input  wire logic        pclk,
    input  wire logic        volt_scan_start,
    input  wire logic        wire_scan_start,
    input  wire logic [13:0] cell_code [12],
    input  wire logic [11:0] supply_open,
    input  wire logic [11:0] gnd_open,
    input  wire logic [12:0] open_pattern,
    input  wire logic [3:0]  gap,
    output logic             sample_valid,
    output logic [3:0]       sample_cell,
    output logic [13:0]      sample_code,
    output logic             sample_supply_open,
    output logic             sample_gnd_open,
    output logic             volt_scan_done,
    output logic             wire_scan_done,
    output logic [12:0]      wire_open
);
    // =========================================================
    // Idle levels at time zero
    initial begin
        sample_valid = 1'b0;
        sample_cell = 4'h0;
        sample_code = 14'h0000;
        sample_supply_open = 1'b0;
        sample_gnd_open = 1'b0;
        volt_scan_done = 1'b0;
        wire_scan_done = 1'b0;
        wire_open = 13'h0000;
    end

    // Start pulses are looked at mid-cycle to stay clear of the launching edge
    always begin
        @(negedge pclk);
        if (volt_scan_start === 1'b1) begin
            for (int i = 0; i < 12; i++) begin
                repeat (gap) @(posedge pclk);
                @(posedge pclk);
                sample_valid <= 1'b1;
                sample_cell <= i[3:0];
                sample_code <= cell_code[i];
                sample_supply_open <= supply_open[i];
                sample_gnd_open <= gnd_open[i];
                @(posedge pclk);
                // Stale data is inverted so nothing leans on the last value
                sample_valid <= 1'b0;
                sample_code <= ~cell_code[i];
                sample_supply_open <= ~supply_open[i];
                sample_gnd_open <= ~gnd_open[i];
            end
            volt_scan_done <= 1'b1;
            @(posedge pclk);
            volt_scan_done <= 1'b0;
        end else if (wire_scan_start === 1'b1) begin
            repeat (gap) @(posedge pclk);
            @(posedge pclk);
            wire_scan_done <= 1'b1;
            wire_open <= open_pattern;
            @(posedge pclk);
            wire_scan_done <= 1'b0;
            wire_open <= ~open_pattern;
        end
    end
endmodule : meas_path_model

`default_nettype wire

/* File: test/test_cell_fault_diagnostics.sv */
// Bench for the cell fault block: APB host tasks, one task per scenario.
// Assumes the measurement path model beside the design and a 250 MHz pclk.
`timescale 1ns/1ps
`default_nettype none

module test_cell_fault_diagnostics;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sample_valid, sample_supply_open, sample_gnd_open;
    logic volt_scan_done, wire_scan_done, volt_scan_start, wire_scan_start;
    logic scan_current_select, status_send, irq;
    logic [3:0] sample_cell, status_word, sent_word, gap = 4'h0;
    logic [13:0] sample_code, codes [12];
    logic [12:0] wire_open, wire_enable, open_pattern = 13'h0000;
    logic [11:0] supply_open = 12'h000, gnd_open = 12'h000;
    int failures = 0, compares = 0, sends = 0;

    // =========================================================
    // Clock, design and partner
    always #2 pclk = ~pclk;

    cell_fault_diagnostics u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample_cell(sample_cell),
        .sample_code(sample_code), .sample_supply_open(sample_supply_open),
        .sample_gnd_open(sample_gnd_open), .volt_scan_done(volt_scan_done),
        .wire_scan_done(wire_scan_done), .wire_open(wire_open), .volt_scan_start(volt_scan_start),
        .wire_scan_start(wire_scan_start), .scan_current_select(scan_current_select),
        .wire_enable(wire_enable), .status_send(status_send), .status_word(status_word), .irq(irq));

    meas_path_model u_meas (.pclk(pclk), .volt_scan_start(volt_scan_start),
        .wire_scan_start(wire_scan_start), .cell_code(codes), .supply_open(supply_open),
        .gnd_open(gnd_open), .open_pattern(open_pattern), .gap(gap), .sample_valid(sample_valid),
        .sample_cell(sample_cell), .sample_code(sample_code),
        .sample_supply_open(sample_supply_open), .sample_gnd_open(sample_gnd_open),
        .volt_scan_done(volt_scan_done), .wire_scan_done(wire_scan_done), .wire_open(wire_open));

    // Unprompted sends are caught mid-cycle, since the pulse lasts one cycle
    always @(negedge pclk) if (status_send === 1'b1) begin
        sends++;
        sent_word = status_word;
    end

    // =========================================================
    // Shared tasks
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; the answer is taken at the edge that samples pready high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
             output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        chk("access cycles", 32'd1, n);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r; logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] r; logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(name, exp, r);
        chk("pslverr", 1'b0, e);
    endtask : rd

    // Issue a scan and poll busy until it ends
    task scan(input logic [31:0] cmd);
        logic [31:0] r; logic e; int n;
        wr(fault_diag_pkg::ADDR_COMMAND, cmd);
        n = 0;
        do begin apb(1'b0, fault_diag_pkg::ADDR_COMMAND, 32'h0, r, e); n++; end
        while (r[0] !== 1'b0 && n < 200);
        chk("scan busy", 1'b0, r[0]);
    endtask : scan

    // =========================================================
    // Scenarios
    task t_reset;
        logic [31:0] r; logic e;
        rd(fault_diag_pkg::ADDR_FAULT_SETUP, 32'h3, "filter code");
        rd(fault_diag_pkg::ADDR_DEVICE_SETUP, 32'h1, "scan current");
        chk("wire enable", 13'h1FFF, wire_enable);
        apb(1'b0, 8'h24, 32'h0, r, e);
        chk("unmapped error", 1'b1, e);
        chk("unmapped data", 32'h0, r);
    endtask : t_reset

    task t_uv;
        wr(fault_diag_pkg::ADDR_FAULT_SETUP, 32'h1);
        wr(fault_diag_pkg::ADDR_CELL_SETUP, 32'h020);
        wr(fault_diag_pkg::ADDR_UV_LIMIT, 32'h1000);
        wr(fault_diag_pkg::ADDR_IRQ_MASK, 32'h1);
        codes[3] = 14'h0FFF; codes[4] = 14'h0FFF; codes[5] = 14'h0000;
        scan(32'h1);
        rd(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h0, "status one sample");
        codes[4] = 14'h1000;
        gap = 4'h3;
        scan(32'h1);
        rd(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h1, "status uv");
        rd(fault_diag_pkg::ADDR_UV_FAULT, 32'h008, "uv fault word");
        chk("sends", 1, sends);
        chk("sent word", 4'h1, sent_word);
        @(negedge pclk);
        chk("irq raised", 1'b1, irq);
        codes[3] = 14'h1FFF; codes[4] = 14'h1FFF; gap = 4'h0;
        scan(32'h1);
        rd(fault_diag_pkg::ADDR_UV_FAULT, 32'h008, "uv sticky");
        wr(fault_diag_pkg::ADDR_UV_FAULT, 32'h008);
        wr(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h1);
        rd(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h0, "status cleared");
        @(negedge pclk);
        chk("irq cleared", 1'b0, irq);
    endtask : t_uv

    task t_restart;
        codes[3] = 14'h0FFF;
        scan(32'h1);
        wr(fault_diag_pkg::ADDR_FAULT_SETUP, 32'h2);
        wr(fault_diag_pkg::ADDR_FAULT_SETUP, 32'h1);
        scan(32'h1);
        rd(fault_diag_pkg::ADDR_UV_FAULT, 32'h000, "after restart");
        scan(32'h1);
        rd(fault_diag_pkg::ADDR_UV_FAULT, 32'h008, "counting again");
        codes[3] = 14'h1FFF;
        wr(fault_diag_pkg::ADDR_UV_FAULT, 32'h008);
        wr(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h1);
    endtask : t_restart

    task t_pin;
        supply_open = 12'h555;
        scan(32'h1);
        rd(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h0, "alternating open");
        supply_open = 12'h003; gnd_open = 12'h800;
        sends = 0;
        scan(32'h1);
        rd(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h2, "supply open");
        chk("pin sent word", 4'h2, sent_word);
        @(negedge pclk);
        chk("irq masked", 1'b0, irq);
        wr(fault_diag_pkg::ADDR_IRQ_MASK, 32'h2);
        repeat (2) @(negedge pclk);  // Irq follows the mask one cycle later
        chk("irq unmasked", 1'b1, irq);
        wr(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h2);
        rd(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h0, "pin cleared");
        supply_open = 12'h000; gnd_open = 12'h000;
    endtask : t_pin

    task t_wire;
        wr(fault_diag_pkg::ADDR_DEVICE_SETUP, 32'h0);
        @(negedge pclk);
        chk("current low", 1'b0, scan_current_select);
        wr(fault_diag_pkg::ADDR_CELL_SETUP, 32'h803);
        repeat (2) @(negedge pclk);  // Enables follow the setup one cycle later
        chk("wire enable", 13'h0FFB, wire_enable);
        open_pattern = 13'h1FFF; gap = 4'h2;
        scan(32'h2);
        rd(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h8, "wire status");
        rd(fault_diag_pkg::ADDR_WIRE_FAULT, 32'h0FFB, "wire fault word");
        wr(fault_diag_pkg::ADDR_WIRE_FAULT, 32'h0FFB);
        wr(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h8);
        rd(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h0, "wire cleared");
        wr(fault_diag_pkg::ADDR_DEVICE_SETUP, 32'h1);
        @(negedge pclk);
        chk("current high", 1'b1, scan_current_select);
    endtask : t_wire

    // =========================================================
    // Verdict, watchdog and main sequence
    task test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    // Whole run needs under a thousand cycles; this leaves wide margin
    initial begin
        #200000;
        failures++;
        test_done;
    end

    initial begin
        for (int i = 0; i < 12; i++) codes[i] = 14'h1FFF;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_uv;
        t_restart;
        t_pin;
        t_wire;
        test_done;
    end
endmodule : test_cell_fault_diagnostics

`default_nettype wire
